// [core/kli_pkg.sv]
// package of register offsets, reset values and sizes for the keyboard level interrupt block
package kli_pkg;
    localparam int         KLI_LINES        = 8;
    localparam logic [7:0] KLI_ADDR_LEVEL   = 8'h9c;
    localparam logic [7:0] KLI_ADDR_ENABLE  = 8'h9d;
    localparam logic [7:0] KLI_ADDR_FLAGS   = 8'h9e;
    localparam logic [7:0] KLI_RESET_LEVEL  = 8'h00;
    localparam logic [7:0] KLI_RESET_ENABLE = 8'h00;
    localparam logic [7:0] KLI_RESET_FLAGS  = 8'h00;
    localparam int         KLI_SYNC_STAGES  = 2;
    typedef enum {KLI_RUN, KLI_IDLE, KLI_POWER_DOWN} kli_power_t;
endpackage

// [core/kli_sync.sv]
// two-stage synchroniser for the keypad port lines
`timescale 1ns/1ns
module kli_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // first stage is read only by the second stage
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // pins idle at their pull-up level, so no false low level follows reset
            stage1_reg <= '1;
            stage2_reg <= '1;
        end
        else
        begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;
endmodule // kli_sync

// [core/kli_keyboard.sv]
// keyboard level interrupt unit: registers, level match, flags, request and wake-up
`timescale 1ns/1ns
// Operation
// - eight keyboard inputs on one port
// - level detection, per-line selectable polarity
// - eight sources merged into one request
// - global enable gates the merged request
// - active level on line n sets flag n
// - line enable gates request, flag always recorded
// - flags read-only, cleared by any read of the flag register
// - enable zero leaves line as plain I/O
// - level select zero detects low level
// - level select one detects high level
// - reset clears all three registers
// - enabled detection wakes from idle, power-down
// - idle bit set enters idle, cleared by interrupt
module kli_keyboard
#(
    parameter int LINES = kli_pkg::KLI_LINES
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [LINES-1:0] keypadPort,
    input  wire logic [7:0]       sfrAddr,
    input  wire logic             sfrWrite,
    input  wire logic             sfrRead,
    input  wire logic [7:0]       sfrWriteData,
    output logic      [7:0]       sfrReadData,
    output logic                  sfrHit,
    input  wire logic             keypadGlobalIrqEnable,
    input  wire logic             idleRequestBitSet,
    input  wire logic             powerDownRequestBitSet,
    input  wire logic             otherIrq,
    output logic                  keyIrqRequest,
    output logic                  idleRequestBit,
    output logic                  powerDownRequestBit,
    output logic                  wakeUp,
    output logic      [LINES-1:0] keyFunctionSelect
);
    import kli_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [LINES-1:0] keyLevelSelect_reg;
    logic [LINES-1:0] keyLevelSelect_next;
    logic [LINES-1:0] keyInputEnable_reg;
    logic [LINES-1:0] keyInputEnable_next;
    logic [LINES-1:0] keyLineFlags_reg;
    logic [LINES-1:0] keyLineFlags_next;
    logic [7:0]       readData_reg;
    logic [7:0]       readData_next;
    kli_power_t       power_reg;
    kli_power_t       power_next;
    logic [LINES-1:0] lineSync;
    logic [LINES-1:0] lineActive;
    logic             flagRead;
    logic             pendingIrq;
    logic             selLevel;
    logic             selEnable;
    logic             selFlags;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // zero-extends a line vector to the byte-wide register bus
    function automatic logic [7:0] widen(input logic [LINES-1:0] v);
        logic [7:0] r;
        r = '0;
        r[LINES-1:0] = v;
        return r;
    endfunction

    // one address compare shared by the write, flag-clear and hit decodes
    function automatic logic addr_match(input logic [7:0] a, input logic [7:0] target);
        return (a == target);
    endfunction

    // xnor per line: select one matches high, select zero matches low
    function automatic logic [LINES-1:0] level_match(input logic [LINES-1:0] pins, input logic [LINES-1:0] sel);
        return ~(pins ^ sel);
    endfunction

    // ----------------------------------------
    // input path
    // ----------------------------------------
    // pins cross into the clock domain before any comparison
    kli_sync #(.WIDTH(LINES)) kli_sync_i (
        .clock   (clock),
        .reset_n (reset_n),
        .asyncIn (keypadPort),
        .syncOut (lineSync)
    );

    assign lineActive = level_match(lineSync, keyLevelSelect_reg);

    assign selLevel  = addr_match(sfrAddr, KLI_ADDR_LEVEL);
    assign selEnable = addr_match(sfrAddr, KLI_ADDR_ENABLE);
    assign selFlags  = addr_match(sfrAddr, KLI_ADDR_FLAGS);
    assign flagRead  = sfrRead && selFlags;
    assign sfrHit    = selLevel || selEnable || selFlags;

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_comb
    begin
        keyLevelSelect_next = keyLevelSelect_reg;
        keyInputEnable_next = keyInputEnable_reg;
        if (sfrWrite && selLevel)
            keyLevelSelect_next = sfrWriteData[LINES-1:0];
        if (sfrWrite && selEnable)
            keyInputEnable_next = sfrWriteData[LINES-1:0];
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            keyLevelSelect_reg <= KLI_RESET_LEVEL[LINES-1:0];
            keyInputEnable_reg <= KLI_RESET_ENABLE[LINES-1:0];
        end
        else
        begin
            keyLevelSelect_reg <= keyLevelSelect_next;
            keyInputEnable_reg <= keyInputEnable_next;
        end
    end

    // ----------------------------------------
    // line flags
    // ----------------------------------------
    // flags ignore writes; a level present during the clearing read sets
    // the bit again, so a held key is never lost: set wins
    always_comb
    begin
        keyLineFlags_next = flagRead ? '0 : keyLineFlags_reg;
        keyLineFlags_next = keyLineFlags_next | lineActive;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            keyLineFlags_reg <= KLI_RESET_FLAGS[LINES-1:0];
        else
            keyLineFlags_reg <= keyLineFlags_next;
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // registered so the flag value returned is the one before the clear
    always_comb
    begin
        readData_next = readData_reg;
        if (sfrRead)
        begin
            case (sfrAddr)
                KLI_ADDR_LEVEL:  readData_next = widen(keyLevelSelect_reg);
                KLI_ADDR_ENABLE: readData_next = widen(keyInputEnable_reg);
                KLI_ADDR_FLAGS:  readData_next = widen(keyLineFlags_reg);
                default:         readData_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            readData_reg <= 8'h00;
        else
            readData_reg <= readData_next;
    end

    // ----------------------------------------
    // request and port function
    // ----------------------------------------
    // masked flags stay recorded; only their request is gated
    assign pendingIrq        = |(keyLineFlags_reg & keyInputEnable_reg);
    assign keyIrqRequest     = pendingIrq && keypadGlobalIrqEnable;
    assign keyFunctionSelect = keyInputEnable_reg;
    assign sfrReadData       = readData_reg;

    // ----------------------------------------
    // power mode
    // ----------------------------------------
    // wake uses the enabled flags regardless of the global gate, since the
    // flag path needs no clock beyond synchroniser in this model
    always_comb
    begin
        power_next = power_reg;
        case (power_reg)
            KLI_RUN:
            begin
                if (powerDownRequestBitSet)
                    power_next = KLI_POWER_DOWN;
                else if (idleRequestBitSet)
                    power_next = KLI_IDLE;
            end
            KLI_IDLE:
            begin
                if (pendingIrq || otherIrq)
                    power_next = KLI_RUN;
            end
            KLI_POWER_DOWN:
            begin
                if (pendingIrq)
                    power_next = KLI_RUN;
            end
            default: power_next = KLI_RUN;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            power_reg <= KLI_RUN;
        else
            power_reg <= power_next;
    end

    // status bits decode the state register, so they settle right after the edge
    assign idleRequestBit      = (power_reg == KLI_IDLE);
    assign powerDownRequestBit = (power_reg == KLI_POWER_DOWN);
    assign wakeUp              = (power_reg != KLI_RUN) && (power_next == KLI_RUN);
endmodule // kli_keyboard

// [bench/kli_keypad_model.sv]
// key matrix model driving the keypad port lines
`timescale 1ns/1ns
module kli_keypad_model (
    input  wire logic [7:0] keyPressed,
    output logic      [7:0] keypadPort
);
    // released keys leave the line at its pull-up level
    assign keypadPort = ~keyPressed;
endmodule // kli_keypad_model

// [bench/kli_keyboard_sva.sv]
// assertion checker for the keyboard level interrupt block
`timescale 1ns/1ns
module kli_keyboard_sva
    import kli_pkg::*;
#(
    parameter int LINES = 8
) (
    input wire logic             clock,
    input wire logic             reset_n,
    input wire logic [LINES-1:0] keypadPort,
    input wire logic [7:0]       sfrAddr,
    input wire logic             sfrWrite,
    input wire logic             sfrRead,
    input wire logic [7:0]       sfrWriteData,
    input wire logic [7:0]       sfrReadData,
    input wire logic             sfrHit,
    input wire logic             keypadGlobalIrqEnable,
    input wire logic             otherIrq,
    input wire logic             keyIrqRequest,
    input wire logic             idleRequestBit,
    input wire logic             powerDownRequestBit,
    input wire logic             wakeUp,
    input wire logic [LINES-1:0] keyFunctionSelect
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    sequence leave_s;
        wakeUp ##1 !idleRequestBit;
    endsequence
    irq_gate_a: assert property (keyIrqRequest |-> keypadGlobalIrqEnable) else $error("irq without global");
    irq_line_a: assert property (keyIrqRequest |-> |keyFunctionSelect) else $error("irq without line");
    fsel_write_a: assert property (sfrWrite && sfrAddr == KLI_ADDR_ENABLE
        |=> keyFunctionSelect == $past(sfrWriteData)) else $error("enable write lost");
    en_read_a: assert property (sfrRead && !sfrWrite && sfrAddr == KLI_ADDR_ENABLE
        |=> sfrReadData == $past(keyFunctionSelect)) else $error("enable read wrong");
    unmap_read_a: assert property (sfrRead && !sfrHit |=> sfrReadData == 8'h00) else $error("unmapped read");
    idle_wake_a: assert property (idleRequestBit && otherIrq |-> leave_s) else $error("idle not left");
    // another source must not end power-down; only enabled key flags may
    pd_hold_a: assert property (powerDownRequestBit && otherIrq && keyFunctionSelect == '0
        |=> powerDownRequestBit) else $error("power-down left");
    rst_clear_a: assert property (disable iff (1'b0) !reset_n |-> keyFunctionSelect == '0 && !keyIrqRequest)
        else $error("reset state wrong");
endmodule // kli_keyboard_sva
bind kli_keyboard kli_keyboard_sva #(.LINES(LINES)) kli_keyboard_sva_i (.clock, .reset_n, .keypadPort, .sfrAddr,
    .sfrWrite, .sfrRead, .sfrWriteData, .sfrReadData, .sfrHit, .keypadGlobalIrqEnable, .otherIrq, .keyIrqRequest,
    .idleRequestBit, .powerDownRequestBit, .wakeUp, .keyFunctionSelect);

// [bench/kli_keyboard_tb_top.sv]
// testbench for the keyboard level interrupt block
`timescale 1ns/1ns
module kli_keyboard_tb_top;
    import kli_pkg::*;
    logic       clock = 1'h0, reset_n = 1'h1, sfrWrite = 1'h0, sfrRead = 1'h0, keypadGlobalIrqEnable = 1'h0;
    logic       idleRequestBitSet = 1'h0, powerDownRequestBitSet = 1'h0, otherIrq = 1'h0;
    logic       sfrHit, keyIrqRequest, idleRequestBit, powerDownRequestBit, wakeUp;
    logic [7:0] sfrAddr = 8'h00, sfrWriteData = 8'h00, keyPressed = 8'h00;
    logic [7:0] keypadPort, sfrReadData, keyFunctionSelect;
    int         fail_count = 0, n_compared = 0;
    kli_keypad_model kli_keypad_model_i (.keyPressed, .keypadPort);
    kli_keyboard kli_keyboard_i (.clock, .reset_n, .keypadPort, .sfrAddr, .sfrWrite, .sfrRead, .sfrWriteData,
        .sfrReadData, .sfrHit, .keypadGlobalIrqEnable, .idleRequestBitSet, .powerDownRequestBitSet, .otherIrq,
        .keyIrqRequest, .idleRequestBit, .powerDownRequestBit, .wakeUp, .keyFunctionSelect);
    initial
        forever #50 clock = ~clock;
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one-cycle strobe, launched and dropped on falling edges
    task automatic acc(logic [7:0] a, logic [7:0] d, logic w);
        @(negedge clock);
        sfrAddr = a;
        sfrWriteData = d;
        sfrWrite = w;
        sfrRead = !w;
        @(negedge clock);
        sfrWrite = 1'h0;
        sfrRead = 1'h0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        acc(a, 8'h00, 1'h0);
        chk("read", exp, sfrReadData);
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        // a real falling edge on reset, before the first clock edge
        #10;
        reset_n = 1'h0;
        repeat (4) @(negedge clock);
        reset_n = 1'h1;
        rd(KLI_ADDR_LEVEL, KLI_RESET_LEVEL);
        rd(KLI_ADDR_ENABLE, KLI_RESET_ENABLE);
        rd(KLI_ADDR_FLAGS, KLI_RESET_FLAGS);
        chk("hit", 8'h01, {7'h00, sfrHit});
        rd(8'h9f, 8'h00);
        chk("hit", 8'h00, {7'h00, sfrHit});
        acc(KLI_ADDR_LEVEL, 8'h0f, 1'h1);
        acc(KLI_ADDR_ENABLE, 8'hff, 1'h1);
        acc(KLI_ADDR_FLAGS, 8'h55, 1'h1);
        rd(KLI_ADDR_LEVEL, 8'h0f);
        rd(KLI_ADDR_FLAGS, 8'h0f);
        chk("irq", 8'h00, {7'h00, keyIrqRequest});
        keypadGlobalIrqEnable = 1'h1;
        @(negedge clock);
        chk("irq", 8'h01, {7'h00, keyIrqRequest});
        keyPressed = 8'h8f;
        repeat (4) @(negedge clock);
        rd(KLI_ADDR_FLAGS, 8'h8f);
        rd(KLI_ADDR_FLAGS, 8'h80);
        acc(KLI_ADDR_ENABLE, 8'h00, 1'h1);
        chk("irq", 8'h00, {7'h00, keyIrqRequest});
        chk("fsel", 8'h00, keyFunctionSelect);
        idleRequestBitSet = 1'h1;
        @(negedge clock);
        idleRequestBitSet = 1'h0;
        chk("idle", 8'h01, {7'h00, idleRequestBit});
        otherIrq = 1'h1;
        @(negedge clock);
        chk("idle", 8'h00, {7'h00, idleRequestBit});
        powerDownRequestBitSet = 1'h1;
        @(negedge clock);
        powerDownRequestBitSet = 1'h0;
        @(negedge clock);
        chk("pd", 8'h01, {7'h00, powerDownRequestBit});
        acc(KLI_ADDR_ENABLE, 8'h80, 1'h1);
        chk("wake", 8'h01, {7'h00, wakeUp});
        @(negedge clock);
        chk("wake", 8'h00, {7'h00, wakeUp});
        @(negedge clock);
        chk("pd", 8'h00, {7'h00, powerDownRequestBit});
        // mid-run reset after the registers were written
        keyPressed = 8'h00;
        reset_n = 1'h0;
        @(negedge clock);
        reset_n = 1'h1;
        rd(KLI_ADDR_LEVEL, KLI_RESET_LEVEL);
        rd(KLI_ADDR_ENABLE, KLI_RESET_ENABLE);
        rd(KLI_ADDR_FLAGS, KLI_RESET_FLAGS);
        chk("irq", 8'h00, {7'h00, keyIrqRequest});
        chk("pd", 8'h00, {7'h00, powerDownRequestBit});
        final_report();
    end
endmodule // kli_keyboard_tb_top
